// ===== common/atfgs_regs.svh
// register offsets, field positions, reset values and codes for the tx format and gpo block
`ifndef ATFGS_REGS_SVH
`define ATFGS_REGS_SVH
`define ATFGS_ADDR_GPO_ONE 7'h18
`define ATFGS_ADDR_GPO_TWO 7'h1a
`define ATFGS_ADDR_TX_FMT 7'h1b
`define ATFGS_GPO_ONE_LSB 0
`define ATFGS_GPO_TWO_LSB 4
`define ATFGS_GPO_ONE_RESET 4'h7
`define ATFGS_GPO_TWO_RESET 4'h4
`define ATFGS_FMT_LSB 0
`define ATFGS_WL_LSB 2
`define ATFGS_BCP_BIT 4
`define ATFGS_LRP_BIT 5
`define ATFGS_FMT_RESET 2'h2
`define ATFGS_WL_RESET 2'h1
`define ATFGS_SEL_BLOCK_START 4'h6
`define ATFGS_SEL_UNLOCK 4'h7
`define ATFGS_SEL_NON_AUDIO 4'h8
`define ATFGS_SEL_CS_UPDATED 4'h9
`define ATFGS_SEL_EMPHASIS 4'ha
`define ATFGS_SEL_COPY_INV 4'hb
`define ATFGS_SEL_ZERO_DATA 4'hc
`define ATFGS_WL_BITS_16 5'h10
`define ATFGS_WL_BITS_20 5'h14
`define ATFGS_WL_BITS_24 5'h18
`endif

// ===== common/atfgs_pkg.sv
// types shared by the tx format and gpo select block
package atfgs_pkg;
    typedef enum logic [1:0] {
        atfgs_fmt_right = 2'h0,
        atfgs_fmt_left = 2'h1,
        atfgs_fmt_i2s = 2'h2,
        atfgs_fmt_dsp = 2'h3
    } atfgs_format_type;

    // the flags that a gpo pin may show
    typedef struct packed {
        logic block_start_marker;
        logic unlock;
        logic non_audio;
        logic channel_status_updated;
        logic emphasis_flag;
        logic copy_permission_inverted;
        logic all_zero_data_flag;
    } atfgs_flags_type;

    // decoded transmit serial settings
    typedef struct packed {
        atfgs_format_type tx_serial_format;
        logic [4:0] word_bits;
        logic tx_bit_clock_invert;
        logic frame_clock_invert;
        logic dsp_mode_b;
    } atfgs_tx_cfg_type;
endpackage

// ===== core/atfgs_gpo_mux.sv
// one output pin source selector
`timescale 1ns/10ps
`include "atfgs_regs.svh"
module atfgs_gpo_mux (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire logic [3:0] select,
    input wire logic enable,
    input wire atfgs_pkg::atfgs_flags_type flags,
    output logic pin
);
    logic next_pin;

    always_comb begin
        next_pin = 1'b0;
        if (enable) begin
            unique case (select)
                `ATFGS_SEL_BLOCK_START: next_pin = flags.block_start_marker;
                `ATFGS_SEL_UNLOCK: next_pin = flags.unlock;
                `ATFGS_SEL_NON_AUDIO: next_pin = flags.non_audio;
                `ATFGS_SEL_CS_UPDATED: next_pin = flags.channel_status_updated;
                `ATFGS_SEL_EMPHASIS: next_pin = flags.emphasis_flag;
                `ATFGS_SEL_COPY_INV: next_pin = flags.copy_permission_inverted;
                `ATFGS_SEL_ZERO_DATA: next_pin = flags.all_zero_data_flag;
                // codes 1101..1111 and unlisted low codes drive low
                default: next_pin = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 1'b0;
        end else if (clock_enable) begin
            pin <= next_pin;
        end
    end

    route_unlock_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && enable && select == `ATFGS_SEL_UNLOCK |=> pin == $past(flags.unlock))
        else $error("pin does not follow unlock flag");
    route_high_codes_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && select > `ATFGS_SEL_ZERO_DATA |=> !pin)
        else $error("pin not low for unused code");
    route_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && enable && select == `ATFGS_SEL_COPY_INV
        |=> pin == $past(flags.copy_permission_inverted))
        else $error("pin does not follow copy flag");
endmodule // atfgs_gpo_mux

// ===== core/atfgs_top.sv
// transmit audio format control and two output pin selectors
//
// Behaviour
// - two-bit field picks tx serial format
// - bits 3:2 set tx word length
// - bit 4 inverts tx bit clock
// - bit 5 frame polarity or dsp mode
// - first selector routes listed status flags
// - selector codes for emphasis, copy, zero
// - selectors work only in two-wire mode
`timescale 1ns/10ps
`include "atfgs_regs.svh"
module atfgs_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire logic two_wire_mode,
    input wire logic reg_write,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire atfgs_pkg::atfgs_flags_type flags,
    output atfgs_pkg::atfgs_tx_cfg_type tx_cfg,
    output logic output_pin_one,
    output logic output_pin_two
);
    logic [7:0] output_pin_one_select;
    logic [7:0] output_pin_two_select;
    logic [7:0] transmit_audio_format_control;
    logic [3:0] output_pin_one_source;
    logic [3:0] output_pin_two_source;
    logic [1:0] tx_serial_format;
    logic [1:0] tx_word_length;
    logic tx_bit_clock_invert;
    logic tx_frame_clock_polarity;
    logic [7:0] next_rdata;
    atfgs_pkg::atfgs_tx_cfg_type next_cfg;

    assign output_pin_one_source = output_pin_one_select[`ATFGS_GPO_ONE_LSB +: 4];
    assign output_pin_two_source = output_pin_two_select[`ATFGS_GPO_TWO_LSB +: 4];
    assign tx_serial_format = transmit_audio_format_control[`ATFGS_FMT_LSB +: 2];
    assign tx_word_length = transmit_audio_format_control[`ATFGS_WL_LSB +: 2];
    assign tx_bit_clock_invert = transmit_audio_format_control[`ATFGS_BCP_BIT];
    assign tx_frame_clock_polarity = transmit_audio_format_control[`ATFGS_LRP_BIT];

    // register writes; bits outside the documented fields are kept for read back
    // a write while the enable is low is dropped, not held over to the next edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            output_pin_one_select <= {4'h0, `ATFGS_GPO_ONE_RESET};
            output_pin_two_select <= {`ATFGS_GPO_TWO_RESET, 4'h0};
            transmit_audio_format_control <= {4'h0, `ATFGS_WL_RESET, `ATFGS_FMT_RESET};
        end else if (clock_enable && reg_write) begin
            unique case (reg_addr)
                `ATFGS_ADDR_GPO_ONE: output_pin_one_select <= reg_wdata;
                `ATFGS_ADDR_GPO_TWO: output_pin_two_select <= reg_wdata;
                `ATFGS_ADDR_TX_FMT: transmit_audio_format_control <= reg_wdata;
                default: ;
            endcase
        end
    end

    // unmapped addresses read as zero so a host probe never sees stale data
    always_comb begin
        unique case (reg_addr)
            `ATFGS_ADDR_GPO_ONE: next_rdata = output_pin_one_select;
            `ATFGS_ADDR_GPO_TWO: next_rdata = output_pin_two_select;
            `ATFGS_ADDR_TX_FMT: next_rdata = transmit_audio_format_control;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clock_enable) begin
            reg_rdata <= next_rdata;
        end
    end

    // decoded settings are registered so the serial side sees one clean change
    always_comb begin
        next_cfg.tx_serial_format = atfgs_pkg::atfgs_format_type'(tx_serial_format);
        unique case (tx_word_length)
            2'h0: next_cfg.word_bits = `ATFGS_WL_BITS_16;
            2'h1: next_cfg.word_bits = `ATFGS_WL_BITS_20;
            2'h2, 2'h3: next_cfg.word_bits = `ATFGS_WL_BITS_24;
        endcase
        // same inversion for master and slave clocking
        next_cfg.tx_bit_clock_invert = tx_bit_clock_invert;
        // bit 5 means polarity outside dsp, sub-mode inside it
        next_cfg.frame_clock_invert = tx_frame_clock_polarity
            && tx_serial_format != 2'h3;
        next_cfg.dsp_mode_b = tx_frame_clock_polarity && tx_serial_format == 2'h3;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // matches the decode of the register defaults, so release causes no step
            tx_cfg <= '{atfgs_pkg::atfgs_fmt_i2s, `ATFGS_WL_BITS_20, 1'b0, 1'b0, 1'b0};
        end else if (clock_enable) begin
            tx_cfg <= next_cfg;
        end
    end

    // both pins share one selector design; two_wire_mode gates them together
    atfgs_gpo_mux pin_one_mux (
        .clock(clock),
        .rst_n(rst_n),
        .clock_enable(clock_enable),
        .select(output_pin_one_source),
        .enable(two_wire_mode),
        .flags(flags),
        .pin(output_pin_one)
    );

    atfgs_gpo_mux pin_two_mux (
        .clock(clock),
        .rst_n(rst_n),
        .clock_enable(clock_enable),
        .select(output_pin_two_source),
        .enable(two_wire_mode),
        .flags(flags),
        .pin(output_pin_two)
    );

    fmt_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable |=> tx_cfg.tx_serial_format == $past(tx_serial_format))
        else $error("tx format not from register");
    wl_map_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && tx_word_length[1] |=> tx_cfg.word_bits == `ATFGS_WL_BITS_24)
        else $error("word length code 1x not 24");
    wl_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && tx_word_length == 2'h0 |=> tx_cfg.word_bits == `ATFGS_WL_BITS_16)
        else $error("word length code 00 not 16");
    bclk_inv_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable |=> tx_cfg.tx_bit_clock_invert == $past(tx_bit_clock_invert))
        else $error("bit clock invert wrong");
    dsp_sub_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && tx_serial_format == 2'h3
        |=> tx_cfg.dsp_mode_b == $past(tx_frame_clock_polarity) && !tx_cfg.frame_clock_invert)
        else $error("dsp sub-mode wrong");
    lr_pol_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && tx_serial_format != 2'h3
        |=> tx_cfg.frame_clock_invert == $past(tx_frame_clock_polarity) && !tx_cfg.dsp_mode_b)
        else $error("frame polarity wrong");
    gpo_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && !two_wire_mode |=> !output_pin_one && !output_pin_two)
        else $error("pin driven outside two-wire mode");
    pin_two_route_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && two_wire_mode && output_pin_two_source == `ATFGS_SEL_ZERO_DATA
        |=> output_pin_two == $past(flags.all_zero_data_flag))
        else $error("second pin zero-data route wrong");
    wl_mid_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && tx_word_length == 2'h1 |=> tx_cfg.word_bits == `ATFGS_WL_BITS_20)
        else $error("word length code 01 not 20");

    // register file: a write lands on the enabled edge that takes it
    fmt_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && reg_write && reg_addr == `ATFGS_ADDR_TX_FMT
        |=> transmit_audio_format_control == $past(reg_wdata))
        else $error("format register write lost");
    pin_one_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && reg_write && reg_addr == `ATFGS_ADDR_GPO_ONE
        |=> output_pin_one_select == $past(reg_wdata))
        else $error("first selector write lost");
    pin_two_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && reg_write && reg_addr == `ATFGS_ADDR_GPO_TWO
        |=> output_pin_two_select == $past(reg_wdata))
        else $error("second selector write lost");
    stray_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && reg_addr != `ATFGS_ADDR_TX_FMT && reg_addr != `ATFGS_ADDR_GPO_ONE
        && reg_addr != `ATFGS_ADDR_GPO_TWO
        |=> $stable(transmit_audio_format_control) && $stable(output_pin_one_select)
        && $stable(output_pin_two_select))
        else $error("unmapped write changed a register");

    // read data lags the address by one enabled edge
    rdata_fmt_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && reg_addr == `ATFGS_ADDR_TX_FMT
        |=> reg_rdata == $past(transmit_audio_format_control))
        else $error("format register read back wrong");
    rdata_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && reg_addr == `ATFGS_ADDR_GPO_ONE
        |=> reg_rdata == $past(output_pin_one_select))
        else $error("first selector read back wrong");
    rdata_two_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && reg_addr == `ATFGS_ADDR_GPO_TWO
        |=> reg_rdata == $past(output_pin_two_select))
        else $error("second selector read back wrong");

    // routes seen at the top-level pins, beside the checks inside the selector
    pin_nonaudio_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && two_wire_mode && output_pin_one_source == `ATFGS_SEL_NON_AUDIO
        |=> output_pin_one == $past(flags.non_audio))
        else $error("first pin non-audio route wrong");
    pin_emphasis_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && two_wire_mode && output_pin_one_source == `ATFGS_SEL_EMPHASIS
        |=> output_pin_one == $past(flags.emphasis_flag))
        else $error("first pin emphasis route wrong");
    pin_block_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_enable && two_wire_mode && output_pin_two_source == `ATFGS_SEL_BLOCK_START
        |=> output_pin_two == $past(flags.block_start_marker))
        else $error("second pin block start route wrong");

    // with the enable low nothing may move, not even the read data
    hold_cfg_a: assert property (@(posedge clock) disable iff (!rst_n)
        !clock_enable |=> $stable(tx_cfg) && $stable(reg_rdata)
        && $stable(transmit_audio_format_control))
        else $error("state moved with clock enable low");
    hold_pins_a: assert property (@(posedge clock) disable iff (!rst_n)
        !clock_enable |=> $stable(output_pin_one) && $stable(output_pin_two))
        else $error("pin moved with clock enable low");

    dsp_b_c: cover property (@(posedge clock) disable iff (!rst_n) tx_cfg.dsp_mode_b);
    wl24_c: cover property (@(posedge clock) disable iff (!rst_n)
        tx_cfg.word_bits == `ATFGS_WL_BITS_24);
    pin_one_high_c: cover property (@(posedge clock) disable iff (!rst_n) output_pin_one);
    pin_two_high_c: cover property (@(posedge clock) disable iff (!rst_n) output_pin_two);
    frame_inv_c: cover property (@(posedge clock) disable iff (!rst_n)
        tx_cfg.frame_clock_invert);
endmodule // atfgs_top

// ===== verification/atfgs_flag_source.sv
// status flag source standing in for the receive side that feeds the selectors
`timescale 1ns/10ps
module atfgs_flag_source (
    input wire logic [2:0] which,
    input wire logic active,
    output atfgs_pkg::atfgs_flags_type flags
);
    // one flag high at a time, so a wrong route shows up as a wrong pin level
    assign flags = active ? atfgs_pkg::atfgs_flags_type'(7'h40 >> which) : '0;
endmodule // atfgs_flag_source

// ===== verification/audio_tx_format_and_gpo_select_tb.sv
// self-checking bench for the tx format and output pin selectors
`timescale 1ns/10ps
module audio_tx_format_and_gpo_select_tb;
    logic clock = 0;
    logic rst_n = 1'b1;
    logic clock_enable = 1;
    logic two_wire_mode = 1;
    logic reg_write = 0;
    logic active = 0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [2:0] which = 3'h0;
    logic [7:0] reg_rdata;
    logic output_pin_one;
    logic output_pin_two;
    logic e;
    atfgs_pkg::atfgs_flags_type flags;
    atfgs_pkg::atfgs_tx_cfg_type tx_cfg;
    int fails = 0;
    int n_checks = 0;
    always #10 clock = ~clock;
    atfgs_top u_atfgs_top (.clock(clock), .rst_n(rst_n), .clock_enable(clock_enable),
        .two_wire_mode(two_wire_mode), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flags(flags), .tx_cfg(tx_cfg),
        .output_pin_one(output_pin_one), .output_pin_two(output_pin_two));
    atfgs_flag_source u_atfgs_flag_source (.which(which), .active(active), .flags(flags));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic note(input logic bad, input logic [9:0] g, input logic [9:0] x);
        n_checks++;
        if (bad) begin
            fails++;
            $display("unexpected at %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
        note(g !== x, {2'h0, g}, {2'h0, x});
    endtask
    task automatic chk_cfg(input logic [9:0] g, input logic [9:0] x);
        note(g !== x, g, x);
    endtask
    task automatic chk_pin(input logic g, input logic x);
        note(g !== x, {9'h0, g}, {9'h0, x});
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_write = 1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_write = 0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] x);
        reg_addr = a;
        tick(1);
        chk_byte(reg_rdata, x);
    endtask
    // frame invert only means something outside dsp format, mode b only inside it
    function automatic logic [9:0] cfg_exp(input logic [7:0] d);
        logic [4:0] wb;
        wb = (d[3:2] == 2'h0) ? 5'h10 : (d[3:2] == 2'h1) ? 5'h14 : 5'h18;
        return {d[1:0], wb, d[4], d[5] & (d[1:0] != 2'h3), d[5] & (d[1:0] == 2'h3)};
    endfunction
    task automatic t_reset;
        chk_cfg(tx_cfg, cfg_exp(8'h06));
        rd_chk(7'h18, 8'h07);
        rd_chk(7'h1a, 8'h40);
        rd_chk(7'h1b, 8'h06);
        rd_chk(7'h19, 8'h00);
    endtask
    task automatic t_format;
        for (int i = 0; i < 64; i++) begin
            wr(7'h1b, 8'(i));
            tick(1);
            chk_cfg(tx_cfg, cfg_exp(8'(i)));
        end
        rd_chk(7'h1b, 8'h3f);
    endtask
    task automatic t_gpo;
        active = 1;
        for (int c = 0; c < 16; c++) begin
            wr(7'h18, 8'(c));
            wr(7'h1a, 8'(c << 4));
            for (int w = 0; w < 7; w++) begin
                which = 3'(w);
                tick(2);
                e = (c >= 6) && (c <= 12) && (c - 6 == w);
                chk_pin(output_pin_one, e);
                chk_pin(output_pin_two, e);
            end
        end
    endtask
    task automatic t_mode;
        wr(7'h18, 8'h07);
        which = 3'h1;
        two_wire_mode = 0;
        tick(2);
        chk_pin(output_pin_one, 1'b0);
        two_wire_mode = 1;
        tick(2);
        chk_pin(output_pin_one, 1'b1);
    endtask
    task automatic t_refuse;
        wr(7'h1b, 8'h33);
        wr(7'h19, 8'hff);
        clock_enable = 0;
        wr(7'h1b, 8'h00);
        clock_enable = 1;
        rd_chk(7'h1b, 8'h33);
        rd_chk(7'h18, 8'h07);
        chk_cfg(tx_cfg, cfg_exp(8'h33));
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        // a real falling edge, so the asynchronous reset is sure to fire
        #1;
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
        tick(1);
        t_reset();
        t_format();
        t_gpo();
        t_mode();
        t_refuse();
        report_and_stop();
    end
    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end
endmodule // audio_tx_format_and_gpo_select_tb
